// ### src/pps_consts.vh
// constants for the power-up sequencer: rails, slots, registers, timing
`ifndef PPS_CONSTS_VH
`define PPS_CONSTS_VH

// rail indices
`define PPS_NRAIL 7
`define PPS_RAIL_AON 0
`define PPS_RAIL_MEM 1
`define PPS_RAIL_AUX 2
`define PPS_RAIL_IO_A 3
`define PPS_RAIL_IO_B 4
`define PPS_RAIL_CORE 5
`define PPS_RAIL_PROC 6

// strobe slot of each rail, 4 bits per rail, rail 6 in the top nibble
`define PPS_RAIL_SLOTS 28'h554_321f
`define PPS_SLOT_AON 4'hf
`define PPS_SLOT_FIRST 4'h1
`define PPS_SLOT_LAST 4'h5

// wishbone register byte offsets
`define PPS_REG_RAIL_CTRL 8'h00
`define PPS_REG_PROC_VSEL 8'h04
`define PPS_REG_MEM_VSEL 8'h08
`define PPS_REG_STATUS 8'h0c
`define PPS_REG_EVENT 8'h10

// reset values, and the processor rail step and base in mV
`define PPS_RAIL_CTRL_RST 7'h7f
`define PPS_PROC_VSEL_RST 6'h00
`define PPS_PROC_STEP_MV 25
`define PPS_PROC_BASE_MV 1100
`define PPS_MEM_VSEL_RST 1'b0

// event bits
`define PPS_EV_BUTTON 0
`define PPS_EV_FAULT 1

// timing
`define PPS_CLK_KHZ 200000
`define PPS_SLOT_TIMEOUT_US 5000
`define PPS_FAULT_LED_MS 200
// 5 ms and 200 ms at 200 MHz, sized to the counter width
`define PPS_SLOT_TIMEOUT_CYC 26'h00f_4240
`define PPS_FAULT_LED_CYC 26'h262_5a00
`define PPS_CNT_W 26

`endif

// ### src/pps_sync2.v
// two-flop synchroniser for a group of pin inputs
module pps_sync2
#(
    parameter W = 1
)
(
    input wire clk_i,          // system clock
    input wire rst_i,          // synchronous reset, active high
    input wire [W-1:0] async_i, // pins from outside the clock domain
    output reg [W-1:0] sync_o   // synchronised levels
);

reg [W-1:0] meta;

always @(posedge clk_i)
begin
    if (rst_i)
    begin
        meta <= {W{1'b0}};
        sync_o <= {W{1'b0}};
    end
    else
    begin
        meta <= async_i;
        sync_o <= meta;
    end
end

endmodule // pps_sync2

// ### src/pps_sequencer.v
// power-up sequencer with wishbone register access
`include "pps_consts.vh"

module pps_sequencer
#(
    parameter [`PPS_CNT_W-1:0] SLOT_TIMEOUT = `PPS_SLOT_TIMEOUT_CYC,
    parameter [`PPS_CNT_W-1:0] FAULT_LED_CYC = `PPS_FAULT_LED_CYC
)
(
    input wire clk_i,                 // 200 MHz clock
    input wire rst_i,                 // synchronous reset, active high
    input wire [7:0] wb_adr_i,        // wishbone byte address
    input wire [31:0] wb_dat_i,       // wishbone write data
    input wire [3:0] wb_sel_i,        // wishbone byte selects
    input wire wb_we_i,               // wishbone write enable
    input wire wb_cyc_i,              // wishbone cycle
    input wire wb_stb_i,              // wishbone strobe
    output reg wb_ack_o,              // wishbone acknowledge
    output reg [31:0] wb_dat_o,       // wishbone read data
    input wire power_on_request_i,    // pin: processor asks for full power
    input wire power_button_i,        // pin: power button, high when pressed
    input wire [6:0] rail_good_i,     // pins: per-rail power good
    output reg [6:0] rail_en_o,       // per-rail regulator enable
    output reg [5:0] proc_vsel_o,     // processor rail, steps above 1.1V
    output reg mem_low_v_o,           // memory rail: 0 = 1.5V, 1 = 1.35V
    output reg clock_rail_good_o,     // releases clock_domain_reset_n
    output reg all_rails_good_o,      // releases main_power_on_reset_n
    output reg power_led_o,           // power indicator
    output wire power_event_irq_o,    // open-drain irq level, always low
    output wire power_event_irq_oe_o, // high while pulling irq low
    output wire wake_o                // wake request to processor
);

localparam [4:0] ST_AON = 5'b00001;
localparam [4:0] ST_IDLE = 5'b00010;
localparam [4:0] ST_STEP = 5'b00100;
localparam [4:0] ST_RUN = 5'b01000;
localparam [4:0] ST_FAULT = 5'b10000;

// rails whose slot is the always-on one or not later than upto
function [6:0] slot_mask;
    input [3:0] upto;
    reg [27:0] slots;
    reg [3:0] s;
    integer r;
    begin
        slot_mask = 7'h00;
        slots = `PPS_RAIL_SLOTS;
        for (r = 0; r < `PPS_NRAIL; r = r + 1)
        begin
            s = slots[4 * r +: 4];
            slot_mask[r] = (s == `PPS_SLOT_AON) || (s <= upto);
        end
    end
endfunction

wire [8:0] pins_sync;
wire req;
wire button;
wire [6:0] good;

pps_sync2 #(.W(9)) u_sync
(
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i({power_button_i, power_on_request_i, rail_good_i}),
    .sync_o(pins_sync)
);

assign good = pins_sync[6:0];
assign req = pins_sync[7];
assign button = pins_sync[8];

reg [4:0] state;
reg [4:0] next_state;
reg [3:0] cur_slot;
reg [3:0] next_slot;
reg [`PPS_CNT_W-1:0] cnt;
reg [`PPS_CNT_W-1:0] next_cnt;
reg button_q;
reg [6:0] rail_ctrl;
reg [1:0] events;
reg fault_set;
reg power_up_start;
wire [6:0] cur_mask;
wire [6:0] next_mask;
wire slot_good;
wire button_press;
wire wb_req;
wire wb_wr;

assign cur_mask = slot_mask(cur_slot);
assign next_mask = slot_mask(next_slot);
assign slot_good = ((good & cur_mask) == cur_mask);
assign button_press = button & ~button_q;
assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
assign wb_wr = wb_req & wb_we_i & wb_sel_i[0];

// sequencing state machine
always @*
begin
    next_state = state;
    next_slot = cur_slot;
    next_cnt = cnt + 1'b1;
    fault_set = 1'b0;
    power_up_start = 1'b0;
    case (state)
        ST_AON:
        begin
            next_cnt = {`PPS_CNT_W{1'b0}};
            if (good[`PPS_RAIL_AON])
                next_state = ST_IDLE;
        end
        ST_IDLE:
        begin
            next_cnt = {`PPS_CNT_W{1'b0}};
            if (req)
            begin
                next_state = ST_STEP;
                next_slot = `PPS_SLOT_FIRST;
                power_up_start = 1'b1;
            end
        end
        ST_STEP:
        begin
            if (!req)
            begin
                next_state = ST_IDLE;
                next_slot = 4'h0;
            end
            else if (slot_good)
            begin
                next_cnt = {`PPS_CNT_W{1'b0}};
                if (cur_slot == `PPS_SLOT_LAST)
                    next_state = ST_RUN;
                else
                    next_slot = cur_slot + 4'h1;
            end
            else if (cnt >= SLOT_TIMEOUT)
            begin
                next_state = ST_FAULT;
                next_slot = 4'h0;
                next_cnt = {`PPS_CNT_W{1'b0}};
                fault_set = 1'b1;
            end
        end
        ST_RUN:
        begin
            next_cnt = {`PPS_CNT_W{1'b0}};
            if (!req)
            begin
                next_state = ST_IDLE;
                next_slot = 4'h0;
            end
        end
        ST_FAULT:
        begin
            if (cnt >= FAULT_LED_CYC)
            begin
                next_cnt = cnt;
                if (!req)
                    next_state = ST_IDLE;
            end
        end
        default:
        begin
            next_state = ST_AON;
            next_slot = 4'h0;
            next_cnt = {`PPS_CNT_W{1'b0}};
        end
    endcase
end

always @(posedge clk_i)
begin
    if (rst_i)
    begin
        state <= ST_AON;
        cur_slot <= 4'h0;
        cnt <= {`PPS_CNT_W{1'b0}};
        button_q <= 1'b0;
    end
    else
    begin
        state <= next_state;
        cur_slot <= next_slot;
        cnt <= next_cnt;
        button_q <= button;
    end
end

// rail enables and status pins
genvar g;
generate
    for (g = 0; g < `PPS_NRAIL; g = g + 1)
    begin : g_rail
        always @(posedge clk_i)
        begin
            if (rst_i)
                rail_en_o[g] <= (g == `PPS_RAIL_AON);
            else if (g == `PPS_RAIL_AON)
                rail_en_o[g] <= 1'b1;
            else if (next_state == ST_STEP)
                rail_en_o[g] <= next_mask[g];
            else if (next_state == ST_RUN)
                rail_en_o[g] <= rail_ctrl[g];
            else
                rail_en_o[g] <= 1'b0;
        end
    end
endgenerate

always @(posedge clk_i)
begin
    if (rst_i)
    begin
        clock_rail_good_o <= 1'b0;
        all_rails_good_o <= 1'b0;
        power_led_o <= 1'b0;
    end
    else
    begin
        clock_rail_good_o <= (next_state != ST_AON);
        all_rails_good_o <= (next_state == ST_RUN);
        power_led_o <= (next_state == ST_RUN) ||
            ((next_state == ST_FAULT) && (next_cnt < FAULT_LED_CYC));
    end
end

// events: set wins over write-one-clear
assign power_event_irq_o = 1'b0;
assign power_event_irq_oe_o = |events;
assign wake_o = events[`PPS_EV_BUTTON];

// registers
always @(posedge clk_i)
begin
    if (rst_i)
    begin
        rail_ctrl <= `PPS_RAIL_CTRL_RST;
        proc_vsel_o <= `PPS_PROC_VSEL_RST;
        mem_low_v_o <= `PPS_MEM_VSEL_RST;
        events <= 2'b00;
    end
    else
    begin
        if (power_up_start)
        begin
            rail_ctrl <= `PPS_RAIL_CTRL_RST;
            proc_vsel_o <= `PPS_PROC_VSEL_RST;
            mem_low_v_o <= `PPS_MEM_VSEL_RST;
        end
        else if (wb_wr)
        begin
            case (wb_adr_i)
                `PPS_REG_RAIL_CTRL:
                    rail_ctrl <= {wb_dat_i[6:1], 1'b1};
                `PPS_REG_PROC_VSEL:
                    proc_vsel_o <= wb_dat_i[5:0];
                `PPS_REG_MEM_VSEL:
                    mem_low_v_o <= wb_dat_i[0];
                default:
                    rail_ctrl <= rail_ctrl;
            endcase
        end
        if (wb_wr && (wb_adr_i == `PPS_REG_EVENT))
            events <= (events & ~wb_dat_i[1:0]) |
                {fault_set, button_press};
        else
            events <= events | {fault_set, button_press};
    end
end

// wishbone answer, one wait state
always @(posedge clk_i)
begin
    if (rst_i)
    begin
        wb_ack_o <= 1'b0;
        wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
        wb_ack_o <= wb_req;
        wb_dat_o <= 32'h0000_0000;
        if (wb_req && !wb_we_i)
        begin
            case (wb_adr_i)
                `PPS_REG_RAIL_CTRL:
                    wb_dat_o <= {25'h000_0000, rail_ctrl};
                `PPS_REG_PROC_VSEL:
                    wb_dat_o <= {26'h000_0000, proc_vsel_o};
                `PPS_REG_MEM_VSEL:
                    wb_dat_o <= {31'h0000_0000, mem_low_v_o};
                `PPS_REG_STATUS:
                    wb_dat_o <= {7'h00, all_rails_good_o, 1'b0, good, 4'h0,
                        cur_slot, 3'h0, state};
                `PPS_REG_EVENT:
                    wb_dat_o <= {30'h0000_0000, events};
                default:
                    wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end
end

endmodule // pps_sequencer

// ### sim/pps_sequencer_props.sv
// concurrent checks on the sequencer ports
module pps_sequencer_props
#(
    parameter [25:0] FAULT_LED_CYC = 26'd20
)
(
    input wire clk_i, // clock
    input wire rst_i, // reset
    input wire wb_cyc_i, // cycle
    input wire wb_stb_i, // strobe
    input wire wb_ack_o, // ack
    input wire power_on_request_i, // request
    input wire [6:0] rail_good_i, // goods
    input wire [6:0] rail_en_o, // enables
    input wire clock_rail_good_o, // clock rail good
    input wire all_rails_good_o, // all good
    input wire power_led_o, // led
    input wire power_event_irq_o, // irq level
    input wire power_event_irq_oe_o, // irq enable
    input wire wake_o // wake
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [25:0] led_run;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // cycles of led lit without all rails good
    always @(posedge clk_i)
    begin
        if (rst_i || !power_led_o || all_rails_good_o)
            led_run <= 26'd0;
        else
            led_run <= led_run + 26'd1;
    end
    a_aon_first: assert property ((|rail_en_o[6:1]) |-> rail_en_o[0])
        else $error("rail on without always-on rail");
    a_crg_cause: assert property ($rose(clock_rail_good_o) |-> $past(rail_good_i[0], 3))
        else $error("clock rail good too early");
    a_slot_mask: assert property (!all_rails_good_o |-> (rail_en_o & (rail_en_o + 7'h01)) == 7'h00)
        else $error("enable mask not slot ordered");
    a_io_order: assert property ($rose(rail_en_o[4]) |-> $past(rail_good_i[3], 2))
        else $error("secondary io before primary good");
    a_good_all: assert property ($rose(all_rails_good_o) |-> $past(&rail_good_i, 2))
        else $error("all good before every rail");
    a_led_good: assert property (all_rails_good_o |-> power_led_o)
        else $error("led off while running");
    a_fault_pulse: assert property (led_run <= FAULT_LED_CYC + 26'd1)
        else $error("fault led pulse too long");
    a_irq_od: assert property (!power_event_irq_o && (!wake_o || power_event_irq_oe_o))
        else $error("irq not open drain or wake alone");
    a_wb_ack: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("no ack one cycle after request");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_power_down: assert property ($fell(power_on_request_i) |-> ##[1:8]
        (rail_en_o == 7'h01 && !all_rails_good_o))
        else $error("rails not off after request drop");
    cover property ($rose(all_rails_good_o));
    cover property ($rose(wake_o));
    cover property (led_run == FAULT_LED_CYC);
endmodule // pps_sequencer_props

bind pps_sequencer pps_sequencer_props #(.FAULT_LED_CYC(FAULT_LED_CYC)) i_props (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .power_on_request_i(power_on_request_i),
    .rail_good_i(rail_good_i), .rail_en_o(rail_en_o),
    .clock_rail_good_o(clock_rail_good_o), .all_rails_good_o(all_rails_good_o),
    .power_led_o(power_led_o), .power_event_irq_o(power_event_irq_o),
    .power_event_irq_oe_o(power_event_irq_oe_o), .wake_o(wake_o));

// ### sim/pps_host_model.sv
// processor and regulator model facing the sequencer
module pps_host_model
(
    input logic clk_i, // clock
    input logic rst_i, // reset
    input logic [6:0] rail_en_i, // enables
    input logic clock_rail_good_i, // clock domain released
    input logic want_i, // bench wants power
    input logic slow_i, // slow rails
    input logic [6:0] kill_i, // rails that never come up
    output logic power_on_request_o = 1'b0, // request
    output logic [6:0] rail_good_o // goods
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] cnt [7] = '{default: 3'd0};
    always @(posedge clk_i)
    begin
        for (int i = 0; i < 7; i++)
        begin
            if (rst_i || !rail_en_i[i] || kill_i[i])
                cnt[i] <= 3'd0;
            else if (cnt[i] != 3'd7)
                cnt[i] <= cnt[i] + 3'd1;
        end
        power_on_request_o <= !rst_i && want_i && clock_rail_good_i;
    end
    always_comb
    begin
        for (int i = 0; i < 7; i++)
            rail_good_o[i] = cnt[i] >= (slow_i ? 3'd7 : 3'd2);
    end
endmodule // pps_host_model

// ### sim/tb_pps_sequencer.sv
// self-checking bench for the power-up sequencer
module tb_pps_sequencer;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 0, rst_i = 1, we = 0, cyc = 0, stb = 0, btn = 0;
    logic want = 0, slow = 0, led_d = 0;
    logic ack, req, lowv, crg, arg, led, irq, irq_oe, wake;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0000_0000, rdat, q;
    logic [6:0] kill = 7'h00, en, good, last_en;
    logic [5:0] vsel;
    logic [7:0] ra [4] = '{8'h00, 8'h04, 8'h08, 8'h14};
    logic [31:0] rv [4] = '{32'h0000_007f, 32'h0, 32'h0, 32'h0};
    logic [6:0] seq [$];
    int miscompares = 0, cmp_count = 0, led_rises = 0;
    pps_sequencer #(.SLOT_TIMEOUT(26'd50), .FAULT_LED_CYC(26'd20)) i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat),
        .wb_sel_i(4'hf), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_ack_o(ack), .wb_dat_o(rdat), .power_on_request_i(req),
        .power_button_i(btn), .rail_good_i(good), .rail_en_o(en),
        .proc_vsel_o(vsel), .mem_low_v_o(lowv), .clock_rail_good_o(crg),
        .all_rails_good_o(arg), .power_led_o(led), .power_event_irq_o(irq),
        .power_event_irq_oe_o(irq_oe), .wake_o(wake));
    pps_host_model i_host (.clk_i(clk_i), .rst_i(rst_i), .rail_en_i(en),
        .clock_rail_good_i(crg), .want_i(want), .slow_i(slow), .kill_i(kill),
        .power_on_request_o(req), .rail_good_o(good));
    initial forever #2.5 clk_i = ~clk_i;
    always @(posedge clk_i)
    begin
        led_d <= led;
        last_en <= en;
        if (led && !led_d) led_rises++;
        if (en !== last_en) seq.push_back(en);
    end
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= a;
        wdat <= d;
        do
        begin
            @(posedge clk_i);
        end
        while (ack !== 1'b1);
        q = rdat;
        cyc <= 0;
        stb <= 0;
    endtask
    task conclude;
        $display("checks %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        #100us;
        miscompares++;
        conclude;
    end
    initial
    begin
        repeat (8) @(posedge clk_i);
        rst_i <= 0;
        chk("rails in reset", en, 7'h01);
        repeat (40) if (crg !== 1'b1) @(posedge clk_i);
        chk("clock rail good", crg, 1'b1);
        chk("rails before request", en, 7'h01);
        foreach (ra[i])
        begin
            wb(0, ra[i], 0);
            chk("reset read", q, rv[i]);
        end
        $display("test reset done");
        seq.delete();
        slow <= 1;
        want <= 1;
        repeat (300) if (arg !== 1'b1) @(posedge clk_i);
        chk("all rails good", arg, 1'b1);
        chk("power led", led, 1'b1);
        chk("slot steps", seq.size(), 5);
        foreach (seq[i]) chk("slot mask", seq[i], i == 4 ? 32'h7f : (32'h4 << i) - 1);
        wb(0, 8'h0c, 0);
        chk("status run", q, 32'h017f_0508);
        $display("test power-up done");
        wb(1, 8'h04, 32'h0000_0004);
        wb(1, 8'h08, 32'h0000_0001);
        repeat (2) @(posedge clk_i);
        chk("proc vsel", vsel, 6'h04);
        chk("mem low", lowv, 1'b1);
        wb(1, 8'h00, 32'h0000_0003);
        repeat (2) @(posedge clk_i);
        chk("clock plus memory", en, 7'h03);
        wb(1, 8'h00, 32'h0000_0000);
        wb(0, 8'h00, 0);
        chk("always-on kept", q, 32'h1);
        repeat (2) @(posedge clk_i);
        chk("clock only", en, 7'h01);
        $display("test control done");
        btn <= 1;
        repeat (4) @(posedge clk_i);
        btn <= 0;
        repeat (4) @(posedge clk_i);
        chk("wake", wake, 1'b1);
        chk("irq enable", irq_oe, 1'b1);
        chk("irq level", irq, 1'b0);
        wb(0, 8'h10, 0);
        chk("button event", q, 32'h1);
        wb(1, 8'h10, 32'h0000_0001);
        repeat (2) @(posedge clk_i);
        chk("irq cleared", irq_oe, 1'b0);
        want <= 0;
        repeat (10) @(posedge clk_i);
        chk("power down rails", en, 7'h01);
        chk("power down good", arg, 1'b0);
        $display("test events done");
        led_rises = 0;
        kill <= 7'h08;
        slow <= 0;
        want <= 1;
        repeat (400) if (led_rises == 0 || led) @(posedge clk_i);
        chk("fault rails", en, 7'h01);
        chk("fault good", arg, 1'b0);
        want <= 0;
        repeat (20) @(posedge clk_i);
        chk("led pulses", led_rises, 1);
        wb(0, 8'h10, 0);
        chk("fault event", q, 32'h2);
        wb(0, 8'h04, 0);
        chk("vsel reloaded", q, 32'h0);
        $display("test fault done");
        conclude;
    end
endmodule // tb_pps_sequencer
